/* File: bench/core_sram_fetch_port_props.sv */
// checker: handshake and status properties of the fetch-side port
`timescale 1ns/1ns
module core_sram_fetch_port_props (
    input wire REF_CLK,
    input wire NRST,
    input wire FETCH_PORT_READ_STROBE,
    input wire FETCH_PORT_WRITE_STROBE,
    input wire FETCH_PORT_SYNC_STROBE,
    input wire FETCH_PORT_WAIT,
    input wire FETCH_PORT_FAULT,
    input wire FETCH_PORT_ABORT_ACK,
    input wire FETCH_PORT_ABORT_REQ,
    input wire FETCH_PORT_WBUF_FLUSH_OK,
    input wire FETCH_PORT_BKPT_HIT,
    input wire FETCH_PORT_RELEASE_ALL,
    input wire DONE,
    input wire BUS_ERROR
);
    logic busy_q;
    wire start = FETCH_PORT_READ_STROBE | FETCH_PORT_WRITE_STROBE | FETCH_PORT_SYNC_STROBE;
    wire busy = start | busy_q;
    // busy spans strobe cycle through the terminating cycle
    always @(posedge REF_CLK) busy_q <= NRST & busy & FETCH_PORT_WAIT;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    sequence s_term; busy && !FETCH_PORT_WAIT; endsequence
    sequence s_stall; busy && FETCH_PORT_WAIT; endsequence
    a_done_after_term: assert property (s_term |=> DONE) else $error("no done after termination");
    a_no_early_done: assert property (s_stall |=> !DONE) else $error("done while stalled");
    a_abort_held: assert property (FETCH_PORT_ABORT_REQ && FETCH_PORT_WAIT |=> FETCH_PORT_ABORT_REQ)
        else $error("abort request dropped early");
    a_abort_drop: assert property (FETCH_PORT_ABORT_REQ && !FETCH_PORT_WAIT |=> !FETCH_PORT_ABORT_REQ)
        else $error("abort request kept after end");
    a_fault_error: assert property (s_term ##0 FETCH_PORT_FAULT |=> DONE && BUS_ERROR)
        else $error("fault without bus error");
    a_stray_ack: assert property (s_term ##0 (FETCH_PORT_ABORT_ACK && !FETCH_PORT_ABORT_REQ) |=> BUS_ERROR)
        else $error("stray ack without bus error");
    a_flush_read: assert property (FETCH_PORT_READ_STROBE |-> !FETCH_PORT_WBUF_FLUSH_OK)
        else $error("flush ok during read start");
    a_release_pulse: assert property ($rose(FETCH_PORT_RELEASE_ALL) |=> !FETCH_PORT_RELEASE_ALL)
        else $error("release pulse too long");
    a_hit_hold: assert property (FETCH_PORT_BKPT_HIT && FETCH_PORT_WAIT |=> FETCH_PORT_BKPT_HIT)
        else $error("break hit dropped early");
    a_hit_end: assert property (s_term ##0 FETCH_PORT_BKPT_HIT |=> !FETCH_PORT_BKPT_HIT)
        else $error("break hit kept after end");
endmodule // core_sram_fetch_port_props

/* File: bench/core_sram_fetch_port_tb.sv */
// testbench for the fetch-side sram port
`timescale 1ns/1ns
module core_sram_fetch_port_tb;
    logic REF_CLK = 0, NRST = 0, BIG_ENDIAN = 0, REQ_VALID = 0, REQ_LINKED = 0, REQ_COND = 0, REQ_BKPT_MATCH = 0;
    logic CORE_ABORT = 0, EXC_RETURN = 0, INSTR_BKPT_ENABLED = 0, DATA_BKPT_ENABLED = 0, ACK_EN = 0, FAULT_EN = 0, LOCK_EN = 0;
    logic [1:0] LANE_ENABLE_MODE = 0, REQ_KIND = 0, REQ_SIZE = 0;
    logic [31:0] REQ_ADDR = 0, REQ_WDATA = 32'h5a5a_0f0f, RWORD = 32'ha5c3_0f96, sa;
    logic [3:0] REQ_LANES = 0, DLY = 0, sl;
    logic [4:0] REQ_STYPE = 0, ss;
    logic [15:0] r;
    logic sf, sw;
    wire REQ_READY, DONE, BUS_ERROR, ABORTED, COND_WRITE_DONE_OK, FETCH_PORT_READ_STROBE, FETCH_PORT_WRITE_STROBE;
    wire FETCH_PORT_SYNC_STROBE, FETCH_PORT_WBUF_FLUSH_OK, FETCH_PORT_IS_FETCH, FETCH_PORT_ABORT_REQ, FETCH_PORT_BKPT_ARMED;
    wire FETCH_PORT_BKPT_HIT, FETCH_PORT_LINKED_READ, FETCH_PORT_COND_WRITE, FETCH_PORT_RELEASE_ALL, FETCH_PORT_WAIT;
    wire FETCH_PORT_FAULT, FETCH_PORT_ABORT_ACK, FETCH_PORT_COND_WRITE_OK;
    wire [31:0] RESULT_WORD, SHARED_WRITE_WORD, FETCH_PORT_READ_WORD;
    wire [3:0] RESULT_LANES, FETCH_PORT_LANE_ENABLES, FETCH_PORT_READ_LANES;
    wire [29:0] FETCH_PORT_WORD_ADDR;
    int checks = 0, n_errors = 0, j, k, nh;
    // {kind, addr[1:0], size, lanes, mode, endian, expected lanes}
    logic [15:0] rows [10] = '{16'h080f, 16'h5002, 16'h5014, 16'h640c, 16'h6413,
                               16'h880f, 16'h8d45, 16'h8d6f, 16'h8ce3, 16'h7008};
    core_sram_fetch_port DUT (.*);
    sram_mem_model mem (.*);
    initial forever #5 REF_CLK = ~REF_CLK;
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task results;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task go(input [1:0] kd, input [31:0] a, input [1:0] s, input [3:0] l);
        int i;
        @(negedge REF_CLK);
        {REQ_KIND, REQ_ADDR, REQ_SIZE, REQ_LANES, REQ_VALID} = {kd, a, s, l, 1'b1};
        for (i = 0; i < 20 && REQ_READY !== 1'b1; i++) @(negedge REF_CLK);
        @(negedge REF_CLK);
        REQ_VALID = 1'b0;
        {sl, sa, sf, sw} = {FETCH_PORT_LANE_ENABLES, 2'b00, FETCH_PORT_WORD_ADDR, FETCH_PORT_IS_FETCH, FETCH_PORT_WBUF_FLUSH_OK};
        ss = {FETCH_PORT_LINKED_READ, FETCH_PORT_COND_WRITE, FETCH_PORT_SYNC_STROBE, FETCH_PORT_WRITE_STROBE, FETCH_PORT_READ_STROBE};
        nh = 0;
        for (i = 0; i < 40 && DONE !== 1'b1; i++) begin
            nh += FETCH_PORT_BKPT_HIT;
            @(negedge REF_CLK);
        end
        chk("done", DONE, 1);
        chk("ready", REQ_READY, 1);
    endtask
    initial begin
        #100000;
        n_errors++;
        results;
    end
    initial begin
        for (j = 0; j < 10; j++) begin
            r = rows[j];
            @(negedge REF_CLK);
            {NRST, LANE_ENABLE_MODE, BIG_ENDIAN} = {1'b0, 1'b0, r[5], r[4]};
            repeat (4) @(negedge REF_CLK);
            chk("ready in reset", {REQ_READY, FETCH_PORT_WBUF_FLUSH_OK, DONE}, 0);
            NRST = 1'b1;
            go(r[15:14], 32'h0000_1230 | r[13:12], r[11:10], r[9:6]);
            chk("lanes", sl, r[3:0]);
            chk("word addr", sa, 32'h0000_048c);
            chk("is fetch", sf, r[15:14] == 2'b00);
            chk("strobes", ss, r[15] ? 2 : 1);
            chk("flush ok", sw, r[15]);
            chk("no hit", nh, 0);
            if (r[15]) chk("write word", SHARED_WRITE_WORD, REQ_WDATA);
        end
        REQ_STYPE = 5'h15;
        go(3, 0, 2, 0);
        chk("sync type", sa[8:4], 5'h15);
        chk("sync strobe", ss, 4);
        {DLY, REQ_BKPT_MATCH, DATA_BKPT_ENABLED} = {4'h2, 1'b1, 1'b1};
        go(0, 32'h0000_0040, 2, 0);
        chk("fetch word", RESULT_WORD, RWORD);
        chk("read lanes", RESULT_LANES, 4'hf);
        chk("armed", FETCH_PORT_BKPT_ARMED, 1);
        chk("hit cycles", nh, 2);
        chk("break kind", sf, 1);
        {REQ_BKPT_MATCH, REQ_LINKED, DLY} = 6'h10;
        go(1, 32'h0000_0044, 2, 0);
        chk("linked", ss, 5'h11);
        {REQ_LINKED, REQ_COND} = 2'b01;
        for (j = 0; j < 2; j++) begin
            LOCK_EN = j;
            go(2, 32'h0000_0048, 2, 0);
            chk("cond flag", ss, 5'h0a);
            chk("cond ok", COND_WRITE_DONE_OK, j);
        end
        {REQ_COND, ACK_EN, DLY, CORE_ABORT} = {1'b0, 1'b1, 4'h5, 1'b1};
        go(0, 32'h0000_004c, 2, 0);
        chk("aborted", {ABORTED, BUS_ERROR}, 2);
        {CORE_ABORT, DLY} = 5'h00;
        go(0, 32'h0000_0050, 2, 0);
        chk("stray ack", {ABORTED, BUS_ERROR}, 1);
        {ACK_EN, FAULT_EN} = 2'b01;
        go(1, 32'h0000_0054, 2, 0);
        chk("fault", BUS_ERROR, 1);
        EXC_RETURN = 1'b1;
        k = 0;
        repeat (6) @(negedge REF_CLK) k += FETCH_PORT_RELEASE_ALL;
        chk("release pulses", k, 1);
        {EXC_RETURN, NRST} = 2'b00;
        repeat (4) @(negedge REF_CLK);
        chk("held in reset", {REQ_READY, FETCH_PORT_WBUF_FLUSH_OK, DONE}, 0);
        NRST = 1'b1;
        @(negedge REF_CLK);
        chk("after reset", {REQ_READY, FETCH_PORT_WBUF_FLUSH_OK, DONE}, 6);
        results;
    end
endmodule // core_sram_fetch_port_tb
bind core_sram_fetch_port core_sram_fetch_port_props props (.*);

/* File: bench/sram_mem_model.sv */
// behavioural memory answering the fetch-side port
`timescale 1ns/1ns
module sram_mem_model (
    input wire REF_CLK,
    input wire FETCH_PORT_READ_STROBE,
    input wire FETCH_PORT_WRITE_STROBE,
    input wire FETCH_PORT_SYNC_STROBE,
    input wire FETCH_PORT_ABORT_REQ,
    input wire FETCH_PORT_COND_WRITE,
    input wire FETCH_PORT_BKPT_ARMED,
    input wire [3:0] DLY,
    input wire ACK_EN,
    input wire FAULT_EN,
    input wire LOCK_EN,
    input wire [31:0] RWORD,
    output wire FETCH_PORT_WAIT,
    output wire FETCH_PORT_FAULT,
    output wire FETCH_PORT_ABORT_ACK,
    output wire FETCH_PORT_COND_WRITE_OK,
    output wire [31:0] FETCH_PORT_READ_WORD,
    output wire [3:0] FETCH_PORT_READ_LANES
);
    reg busy_q = 1'b0;
    reg [3:0] cnt_q = 4'h0;
    wire start = FETCH_PORT_READ_STROBE | FETCH_PORT_WRITE_STROBE | FETCH_PORT_SYNC_STROBE;
    wire act = start | busy_q;
    // while breakpoints are armed every transaction is stalled at least one cycle
    wire [3:0] left = start ? ((FETCH_PORT_BKPT_ARMED && DLY == 4'h0) ? 4'h1 : DLY) : cnt_q;
    // an honoured abort still ends only by dropping wait
    wire term = act & ((left == 4'h0) | (FETCH_PORT_ABORT_REQ & ACK_EN));
    assign FETCH_PORT_WAIT = act & ~term;
    assign FETCH_PORT_FAULT = term & FAULT_EN;
    assign FETCH_PORT_ABORT_ACK = term & ACK_EN;
    assign FETCH_PORT_COND_WRITE_OK = term & FETCH_PORT_COND_WRITE & LOCK_EN;
    // outside the terminating cycle the data lines show junk
    assign FETCH_PORT_READ_WORD = term ? RWORD : ~RWORD;
    assign FETCH_PORT_READ_LANES = term ? 4'hf : 4'h0;
    always @(posedge REF_CLK) begin
        busy_q <= act & ~term;
        cnt_q <= left - 4'h1;
    end
endmodule // sram_mem_model

/* File: hdl/core_sram_fetch_port.v */
// fetch-side sram port of the core: transaction sequencing and status
`timescale 1ns/1ns
`include "core_sram_fetch_port_regs.vh"

module core_sram_fetch_port #(
    parameter UNIFIED = 1
) (
    input wire REF_CLK,
    input wire NRST,
    // static configuration
    input wire [1:0] LANE_ENABLE_MODE,
    input wire BIG_ENDIAN,
    // core side request
    input wire REQ_VALID,
    input wire [1:0] REQ_KIND,
    input wire [31:0] REQ_ADDR,
    input wire [1:0] REQ_SIZE,
    input wire [3:0] REQ_LANES,
    input wire [31:0] REQ_WDATA,
    input wire [4:0] REQ_STYPE,
    input wire REQ_LINKED,
    input wire REQ_COND,
    input wire REQ_BKPT_MATCH,
    output reg REQ_READY,
    input wire CORE_ABORT,
    input wire EXC_RETURN,
    input wire INSTR_BKPT_ENABLED,
    input wire DATA_BKPT_ENABLED,
    // core side result
    output reg DONE,
    output reg BUS_ERROR,
    output reg ABORTED,
    output reg COND_WRITE_DONE_OK,
    output reg [31:0] RESULT_WORD,
    output reg [3:0] RESULT_LANES,
    // memory side
    output reg FETCH_PORT_READ_STROBE,
    output reg FETCH_PORT_WRITE_STROBE,
    output reg FETCH_PORT_SYNC_STROBE,
    output reg FETCH_PORT_WBUF_FLUSH_OK,
    output reg FETCH_PORT_IS_FETCH,
    output reg [29:0] FETCH_PORT_WORD_ADDR,
    output reg [3:0] FETCH_PORT_LANE_ENABLES,
    output reg [31:0] SHARED_WRITE_WORD,
    output reg FETCH_PORT_ABORT_REQ,
    output reg FETCH_PORT_BKPT_ARMED,
    output reg FETCH_PORT_BKPT_HIT,
    output reg FETCH_PORT_LINKED_READ,
    output reg FETCH_PORT_COND_WRITE,
    output reg FETCH_PORT_RELEASE_ALL,
    input wire FETCH_PORT_WAIT,
    input wire FETCH_PORT_FAULT,
    input wire FETCH_PORT_ABORT_ACK,
    input wire FETCH_PORT_COND_WRITE_OK,
    input wire [31:0] FETCH_PORT_READ_WORD,
    input wire [3:0] FETCH_PORT_READ_LANES
);

    reg state_q;
    reg state_d;
    reg bkpt_pend_q;
    reg ret_prev_q;
    reg [3:0] lanes_d;
    reg free_ok;
    reg [29:0] addr_d;
    wire [1:0] lane_idx;
    wire [3:0] byte_lanes;
    wire [3:0] half_lanes;
    wire accept;
    wire term;
    wire req_fetch_port_read_strobe;
    wire req_is_write;
    wire req_fetch_port_sync_strobe;
    wire bkpt_armed_d;

    // memory ends the transaction in the first cycle with wait low
    assign term = (state_q == `ST_BUSY) & ~FETCH_PORT_WAIT;
    // a request is taken only while idle and ready is shown
    assign accept = (state_q == `ST_IDLE) & REQ_READY & REQ_VALID;
    assign req_fetch_port_read_strobe = (REQ_KIND == `KIND_FETCH) | (REQ_KIND == `KIND_READ);
    assign req_is_write = (REQ_KIND == `KIND_WRITE);
    assign req_fetch_port_sync_strobe = (REQ_KIND == `KIND_SYNC);
    assign lane_idx = BIG_ENDIAN ? ~REQ_ADDR[1:0] : REQ_ADDR[1:0];
    // data breakpoints only count when this port also carries data
    assign bkpt_armed_d = INSTR_BKPT_ENABLED | ((UNIFIED != 0) & DATA_BKPT_ENABLED);

    always @* begin
        state_d = state_q;
        case (state_q)
            `ST_IDLE: begin
                if (accept) begin
                    state_d = `ST_BUSY;
                end
            end
            `ST_BUSY: begin
                if (term) begin
                    state_d = `ST_IDLE;
                end
            end
            default: begin
                state_d = `ST_IDLE;
            end
        endcase
    end

    // per lane select for byte and halfword accesses
    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1) begin : g_lane
            assign byte_lanes[n] = (lane_idx == n);
            // halfword lanes follow address bit 1, mirrored in big-endian mode
            assign half_lanes[n] = ((n / 2) == (REQ_ADDR[1] ^ BIG_ENDIAN));
        end
    endgenerate

    // lane enable generation from size and free pattern
    always @* begin
        free_ok = 1'b0;
        case (REQ_LANES)
            4'h1, 4'h2, 4'h4, 4'h8, `LANES_LOW_HALF, `LANES_HIGH_HALF, `LANES_ALL: begin
                free_ok = 1'b1;
            end
            default: begin
                free_ok = 1'b0;
            end
        endcase
        case (REQ_SIZE)
            `SIZE_BYTE: begin
                lanes_d = byte_lanes;
            end
            `SIZE_HALF: begin
                lanes_d = half_lanes;
            end
            `SIZE_WORD: begin
                lanes_d = `LANES_ALL;
            end
            default: begin
                // aligned mode (and the reserved codes) widen odd patterns to a word
                if (LANE_ENABLE_MODE == `LANE_MODE_ANY || free_ok) begin
                    lanes_d = REQ_LANES;
                end else begin
                    lanes_d = `LANES_ALL;
                end
            end
        endcase
        if (REQ_KIND == `KIND_FETCH || req_fetch_port_sync_strobe) begin
            lanes_d = `LANES_ALL;
        end
    end

    // sync transactions carry the sync type in the address field
    always @* begin
        addr_d = REQ_ADDR[31:2];
        if (req_fetch_port_sync_strobe) begin
            addr_d[`STYPE_MSB-2:`STYPE_LSB-2] = REQ_STYPE;
        end
    end

    // sequencer state; everything moves on the rising core clock edge
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            state_q <= `ST_IDLE;
            REQ_READY <= 1'b0;
        end else begin
            state_q <= state_d;
            REQ_READY <= (state_d == `ST_IDLE);
        end
    end

    // strobes are one-cycle pulses at transaction start
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_READ_STROBE <= 1'b0;
            FETCH_PORT_WRITE_STROBE <= 1'b0;
            FETCH_PORT_SYNC_STROBE <= 1'b0;
        end else begin
            FETCH_PORT_READ_STROBE <= accept & req_fetch_port_read_strobe;
            FETCH_PORT_WRITE_STROBE <= accept & req_is_write;
            FETCH_PORT_SYNC_STROBE <= accept & req_fetch_port_sync_strobe;
        end
    end

    // registered from the request alone; a pending transaction is assumed to end now
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_WBUF_FLUSH_OK <= 1'b0;
        end else begin
            FETCH_PORT_WBUF_FLUSH_OK <= ~(REQ_VALID & req_fetch_port_read_strobe);
        end
    end

    // transaction attributes, held until the next start
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_IS_FETCH <= 1'b0;
            FETCH_PORT_WORD_ADDR <= 30'h0000_0000;
            FETCH_PORT_LANE_ENABLES <= `LANES_NONE;
            SHARED_WRITE_WORD <= `WORD_ZERO;
        end else if (accept) begin
            FETCH_PORT_IS_FETCH <= (REQ_KIND == `KIND_FETCH);
            FETCH_PORT_WORD_ADDR <= addr_d;
            FETCH_PORT_LANE_ENABLES <= lanes_d;
            // data-side write word serves this port in unified builds
            SHARED_WRITE_WORD <= REQ_WDATA;
        end
    end

    // lock flags and breakpoint match live from start to termination
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_LINKED_READ <= 1'b0;
            FETCH_PORT_COND_WRITE <= 1'b0;
            bkpt_pend_q <= 1'b0;
        end else if (accept) begin
            FETCH_PORT_LINKED_READ <= REQ_LINKED & (REQ_KIND == `KIND_READ);
            FETCH_PORT_COND_WRITE <= REQ_COND & req_is_write;
            bkpt_pend_q <= REQ_BKPT_MATCH;
        end else if (term) begin
            FETCH_PORT_LINKED_READ <= 1'b0;
            FETCH_PORT_COND_WRITE <= 1'b0;
            bkpt_pend_q <= 1'b0;
        end
    end

    // once raised, held through the terminating cycle
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_ABORT_REQ <= 1'b0;
        end else if (term) begin
            FETCH_PORT_ABORT_REQ <= 1'b0;
        end else if (state_q == `ST_BUSY && CORE_ABORT) begin
            FETCH_PORT_ABORT_REQ <= 1'b1;
        end
    end

    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_BKPT_ARMED <= 1'b0;
        end else begin
            FETCH_PORT_BKPT_ARMED <= bkpt_armed_d;
        end
    end

    // rises the cycle after start, falls after termination
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            FETCH_PORT_BKPT_HIT <= 1'b0;
        end else begin
            FETCH_PORT_BKPT_HIT <= (state_q == `ST_BUSY) & ~term & bkpt_pend_q;
        end
    end

    // one pulse per rising edge of the return request
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            ret_prev_q <= 1'b0;
            FETCH_PORT_RELEASE_ALL <= 1'b0;
        end else begin
            ret_prev_q <= EXC_RETURN;
            FETCH_PORT_RELEASE_ALL <= EXC_RETURN & ~ret_prev_q;
        end
    end

    // status capture at termination only
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            DONE <= 1'b0;
            BUS_ERROR <= 1'b0;
            ABORTED <= 1'b0;
            COND_WRITE_DONE_OK <= 1'b0;
        end else begin
            DONE <= term;
            if (term) begin
                BUS_ERROR <= FETCH_PORT_FAULT | (FETCH_PORT_ABORT_ACK & ~FETCH_PORT_ABORT_REQ);
                ABORTED <= FETCH_PORT_ABORT_ACK & FETCH_PORT_ABORT_REQ;
                COND_WRITE_DONE_OK <= FETCH_PORT_COND_WRITE & FETCH_PORT_COND_WRITE_OK;
            end
        end
    end

    // read data and its lanes are junk outside the terminating cycle
    always @(posedge REF_CLK) begin
        if (!NRST) begin
            RESULT_WORD <= `WORD_ZERO;
            RESULT_LANES <= `LANES_NONE;
        end else if (term) begin
            RESULT_WORD <= FETCH_PORT_READ_WORD;
            RESULT_LANES <= FETCH_PORT_READ_LANES;
        end
    end

endmodule // core_sram_fetch_port

/* File: pkg/core_sram_fetch_port_regs.vh */
// constants for the fetch-side sram port
`ifndef CORE_SRAM_FETCH_PORT_REGS_VH
`define CORE_SRAM_FETCH_PORT_REGS_VH

`define ST_IDLE 1'b0
`define ST_BUSY 1'b1

`define KIND_FETCH 2'h0
`define KIND_READ 2'h1
`define KIND_WRITE 2'h2
`define KIND_SYNC 2'h3

`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define SIZE_FREE 2'h3

`define LANE_MODE_ANY 2'h0
`define LANE_MODE_ALIGNED 2'h1

`define LANES_ALL 4'hf
`define LANES_LOW_HALF 4'h3
`define LANES_HIGH_HALF 4'hc
`define LANES_NONE 4'h0

`define STYPE_LSB 6
`define STYPE_MSB 10

`define WORD_ZERO 32'h0000_0000

`endif
